// ==== logic/peqm_top.sv ====
`include "peqm_defines.svh"

module peqm_top #(
    parameter int CNT_W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // hub request observation
    input wire logic hub_req_valid,
    input wire logic hub_sched,
    input wire logic hub_bank,
    input wire logic [1:0] hub_evict,
    input wire logic hub_locked,
    input wire logic [1:0] hub_l2_state,
    input wire logic [1:0] hub_l1_state,
    input wire logic hub_full_line,
    input wire logic [1:0] hub_cca,
    input wire logic [4:0] hub_cmd,
    input wire logic hub_core_coherent,
    input wire logic hub_l1_writeback,
    input wire logic hub_reg_target,
    input wire logic hub_thread,
    input wire logic [3:0] hub_port,
    // io request observation
    input wire logic io_req_valid,
    input wire logic [2:0] io_unit,
    input wire logic [4:0] io_tid,
    input wire logic [5:0] io_did,
    input wire logic io_prefetch,
    input wire logic io_misaligned,
    input wire logic [8:0] io_len,
    input wire logic [2:0] io_size_log2,
    input wire logic [2:0] io_dir,
    // memory request observation
    input wire logic mem_req_valid,
    input wire logic [4:0] mem_gid,
    input wire logic mem_prefetch,
    input wire logic mem_code,
    input wire logic mem_thread,
    // io unit bus beats, one per unit
    input wire logic [7:0] io_axi_beat,
    // trace unit
    input wire logic trace_drop,
    input wire logic trace_drop_resp,
    input wire logic [2:0] trace_drop_port,
    input wire logic trace_ovf_busy,
    output logic count_active
);
    logic [4:0] evsel;
    logic [63:0] qual;
    logic count_en;
    logic [CNT_W-1:0] count;
    logic count_wrap;
    peqm_pkg::peqm_state_type state;
    logic [8:0] len_bin;
    logic hub_hit;
    logic io_hit;
    logic mem_hit;
    logic trace_hit;
    logic axi_hit;
    logic event_hit;
    logic wr_en;
    logic rd_en;

    // one-hot of a small index into a mask, anded with the group
    function automatic logic sel_bit(input logic [15:0] grp, input logic [3:0] idx);
        sel_bit = grp[idx];
    endfunction

    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == `PEQM_OFF_EVSEL) || (a == `PEQM_OFF_QUAL_LO) ||
            (a == `PEQM_OFF_QUAL_HI) || (a == `PEQM_OFF_CTRL) ||
            (a == `PEQM_OFF_COUNT) || (a == `PEQM_OFF_STATUS);
    endfunction

    assign wr_en = psel && penable && pwrite && clk_en;
    assign rd_en = psel && !penable && !pwrite && clk_en;

    peqm_len_bin u_len_bin (
        .len(io_len),
        .bin(len_bin)
    );

    // hub request: every group must pass
    always_comb begin
        logic [4:0] cmd;
        cmd = hub_cmd;
        if (hub_l1_writeback && hub_core_coherent) begin
            cmd = `PEQM_HQ_CMD_WB;
        end
        hub_hit = hub_req_valid
            && sel_bit({14'h0000, qual[60:59]}, {3'h0, hub_sched})
            && sel_bit({14'h0000, qual[58:57]}, {3'h0, hub_bank})
            && sel_bit({13'h0000, qual[56:54]}, {2'h0, hub_evict})
            && sel_bit({14'h0000, qual[53:52]}, {3'h0, hub_locked})
            && sel_bit({12'h000, qual[51:48]}, {2'h0, hub_l2_state})
            && sel_bit({13'h0000, qual[47:45]}, {2'h0, hub_l1_state})
            && sel_bit({14'h0000, qual[44:43]}, {3'h0, hub_full_line})
            && sel_bit({13'h0000, qual[42:40]}, {2'h0, hub_cca})
            && qual[`PEQM_HQ_CMD + 32'(cmd)]
            && sel_bit({14'h0000, qual[15:14]}, {3'h0, hub_reg_target})
            && sel_bit({14'h0000, qual[11:10]}, {3'h0, hub_thread})
            && sel_bit({6'h00, qual[9:0]}, hub_port);
    end

    // io request qualification
    always_comb begin
        io_hit = io_req_valid
            && (io_unit == qual[2:0])
            && (qual[`PEQM_IQ_TID_ALL] || io_tid == qual[41:37])
            && (qual[`PEQM_IQ_DID_ALL] || io_did == qual[35:30])
            && sel_bit({14'h0000, qual[28:27]}, {3'h0, io_prefetch})
            && sel_bit({14'h0000, qual[26:25]}, {3'h0, io_misaligned})
            && |(len_bin & qual[24:16])
            && sel_bit({8'h00, qual[15:8]}, {1'h0, io_size_log2})
            && sel_bit({11'h000, qual[7:3]}, {1'h0, io_dir});
    end

    // memory request: guest id, prefetch, code/data, thread
    always_comb begin
        mem_hit = mem_req_valid
            && (qual[`PEQM_MQ_GID_ALL] || mem_gid == qual[45:41])
            && sel_bit({14'h0000, qual[39:38]}, {3'h0, mem_prefetch})
            && sel_bit({14'h0000, qual[37:36]}, {3'h0, mem_code})
            && sel_bit({14'h0000, qual[33:32]}, {3'h0, mem_thread});
    end

    always_comb begin
        trace_hit = trace_drop
            && (trace_drop_resp ? qual[`PEQM_TQ_RESP] : qual[`PEQM_TQ_REQ])
            && sel_bit({10'h000, qual[5:0]}, {1'h0, trace_drop_port});
        // codes 9..15 map onto units 1..7
        axi_hit = (evsel >= `PEQM_EV_AXI_FIRST) && (evsel <= `PEQM_EV_AXI_LAST)
            && io_axi_beat[3'(evsel - 5'h08)];
    end

    always_comb begin
        case (evsel)
            `PEQM_EV_HUB_REQ: event_hit = hub_hit;
            `PEQM_EV_IO_REQ: event_hit = io_hit;
            `PEQM_EV_MEM_REQ: event_hit = mem_hit;
            `PEQM_EV_TRACE_DROP: event_hit = trace_hit;
            `PEQM_EV_TRACE_OVF: event_hit = trace_ovf_busy;
            default: event_hit = axi_hit;
        endcase
    end

    // software registers; reserved hub bits kept as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evsel <= `PEQM_EV_NONE;
            qual <= `PEQM_QUAL_RESET;
            count_en <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `PEQM_OFF_EVSEL: evsel <= pwdata[4:0];
                `PEQM_OFF_QUAL_LO: qual[31:0] <= pwdata;
                `PEQM_OFF_QUAL_HI: qual[63:32] <= pwdata;
                `PEQM_OFF_CTRL: count_en <= pwdata[0];
                default: evsel <= evsel;
            endcase
        end
    end

    // run state follows the enable bit; a wrap does not stop counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= peqm_pkg::PEQM_IDLE;
        end else if (clk_en) begin
            case (state)
                peqm_pkg::PEQM_IDLE: if (count_en) state <= peqm_pkg::PEQM_RUN;
                peqm_pkg::PEQM_RUN: if (!count_en) state <= peqm_pkg::PEQM_IDLE;
                peqm_pkg::PEQM_HOLD: if (!count_en) state <= peqm_pkg::PEQM_IDLE;
                default: state <= peqm_pkg::PEQM_IDLE;
            endcase
        end
    end

    // single increment per cycle; a software write to count wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            count_wrap <= 1'b0;
        end else if (clk_en) begin
            if (wr_en && paddr == `PEQM_OFF_COUNT) begin
                count <= CNT_W'(pwdata);
                count_wrap <= 1'b0;
            end else if (state == peqm_pkg::PEQM_RUN && count_en && event_hit) begin
                count <= count + 1'b1;
                if (&count) begin
                    count_wrap <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_active <= 1'b0;
        end else if (clk_en) begin
            count_active <= (state == peqm_pkg::PEQM_RUN) && count_en;
        end
    end

    // apb: zero wait state, data registered in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !reg_hit(paddr);
            if (rd_en) begin
                case (paddr)
                    `PEQM_OFF_EVSEL: prdata <= {27'h0000000, evsel};
                    `PEQM_OFF_QUAL_LO: prdata <= qual[31:0];
                    `PEQM_OFF_QUAL_HI: prdata <= qual[63:32];
                    `PEQM_OFF_CTRL: prdata <= {31'h00000000, count_en};
                    `PEQM_OFF_COUNT: prdata <= 32'(count);
                    `PEQM_OFF_STATUS: prdata <= {29'h00000000, state == peqm_pkg::PEQM_RUN,
                        count_wrap, hub_hit};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// ==== logic/peqm_defines.svh ====
`ifndef PEQM_DEFINES_SVH
`define PEQM_DEFINES_SVH

// register byte offsets
`define PEQM_OFF_EVSEL 12'h000
`define PEQM_OFF_QUAL_LO 12'h004
`define PEQM_OFF_QUAL_HI 12'h008
`define PEQM_OFF_CTRL 12'h00c
`define PEQM_OFF_COUNT 12'h010
`define PEQM_OFF_STATUS 12'h014

// event codes
`define PEQM_EV_NONE 5'h00
`define PEQM_EV_HUB_REQ 5'h01
`define PEQM_EV_IO_REQ 5'h02
`define PEQM_EV_MEM_REQ 5'h03
`define PEQM_EV_AXI_FIRST 5'h09
`define PEQM_EV_AXI_LAST 5'h0f
`define PEQM_EV_TRACE_DROP 5'h11
`define PEQM_EV_TRACE_OVF 5'h12

// hub-request qualifier positions
`define PEQM_HQ_RSVD_HI 63
`define PEQM_HQ_RSVD_LO 61
`define PEQM_HQ_SCHED 59
`define PEQM_HQ_BANK 57
`define PEQM_HQ_EVICT 54
`define PEQM_HQ_LOCK 52
`define PEQM_HQ_L2ST 48
`define PEQM_HQ_L1ST 45
`define PEQM_HQ_SIZE 43
`define PEQM_HQ_CCA 40
`define PEQM_HQ_CMD 16
`define PEQM_HQ_CMD_WB 5'h08
`define PEQM_HQ_CMD_LEGW 5'h01
`define PEQM_HQ_TGT 14
`define PEQM_HQ_THR 10
`define PEQM_HQ_PORT 0

// io qualifier positions
`define PEQM_IQ_TID 37
`define PEQM_IQ_TID_ALL 36
`define PEQM_IQ_DID 30
`define PEQM_IQ_DID_ALL 29
`define PEQM_IQ_PF 27
`define PEQM_IQ_ALIGN 25
`define PEQM_IQ_LEN 16
`define PEQM_IQ_SIZE 8
`define PEQM_IQ_DIR 3
`define PEQM_IQ_UNIT 0

// memory qualifier positions
`define PEQM_MQ_GID 41
`define PEQM_MQ_GID_ALL 40
`define PEQM_MQ_PF 38
`define PEQM_MQ_CODE 36
`define PEQM_MQ_THR 32

// trace drop qualifier positions
`define PEQM_TQ_RESP 7
`define PEQM_TQ_REQ 6
`define PEQM_TQ_PORT 0

`define PEQM_QUAL_RESET 64'hffffffffffffffff

`endif

// ==== logic/peqm_pkg.sv ====
package peqm_pkg;
    typedef enum logic [2:0] {
        PEQM_IDLE = 3'b001,
        PEQM_RUN = 3'b010,
        PEQM_HOLD = 3'b100
    } peqm_state_type;
endpackage

// ==== logic/peqm_len_bin.sv ====
// maps a burst length to its one-hot bin
module peqm_len_bin (
    input wire logic [8:0] len,
    output logic [8:0] bin
);
    always_comb begin
        bin = 9'h000;
        if (len <= 9'h001) begin
            bin[0] = 1'b1;
        end else if (len == 9'h002) begin
            bin[1] = 1'b1;
        end else if (len <= 9'h004) begin
            bin[2] = 1'b1;
        end else if (len <= 9'h008) begin
            bin[3] = 1'b1;
        end else if (len <= 9'h010) begin
            bin[4] = 1'b1;
        end else if (len <= 9'h020) begin
            bin[5] = 1'b1;
        end else if (len <= 9'h040) begin
            bin[6] = 1'b1;
        end else if (len <= 9'h080) begin
            bin[7] = 1'b1;
        end else begin
            bin[8] = 1'b1;
        end
    end
endmodule

// ==== verif/peqm_top_props.sv ====
`include "peqm_defines.svh"
module peqm_top_props #(parameter int CNT_W = 32) (
    input logic pclk,
    input logic presetn,
    input logic clk_en,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic count_active
);
    timeunit 1ns;
    timeprecision 1ps;
    wire ctrl_on = psel && pwrite && paddr == `PEQM_OFF_CTRL && pwdata[0];
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_setup_answer;
        psel && !penable && clk_en |=> pready;
    endproperty
    a_setup_answer: assert property (p_setup_answer) else $error("no answer");
    property p_ready_once;
        pready && clk_en |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready stuck");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("lone error");
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("stray ready");
    property p_unmapped;
        pready && paddr > `PEQM_OFF_STATUS |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
    property p_mapped;
        pready && paddr <= `PEQM_OFF_STATUS && paddr[1:0] == 2'b00 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped refused");
    property p_run_cause;
        $rose(count_active) |-> $past(ctrl_on) || $past(ctrl_on, 2) || $past(ctrl_on, 3);
    endproperty
    a_run_cause: assert property (p_run_cause) else $error("run without enable");
    property p_reset_quiet;
        $rose(presetn) |-> !pready && !pslverr && !count_active;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
endmodule
bind peqm_top peqm_top_props #(.CNT_W(CNT_W)) i_props (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_active(count_active));

// ==== verif/peqm_far.sv ====
module peqm_far (
    input logic pclk,
    output logic [3:0][31:0] req,
    output logic [8:0] lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req = '0;
        lvl = '0;
    end
    // fields go inverted after the pulse so a stale copy never matches
    task send(input int ch, input logic [30:0] f);
        req[ch] <= {1'b1, f};
        @(posedge pclk);
        req[ch] <= {1'b0, ~f};
        @(posedge pclk);
    endtask
    task hold(input logic [8:0] v, input int n, input int m);
        lvl <= v;
        repeat (n) @(posedge pclk);
        lvl <= {1'b0, ~v[7:0]};
        repeat (m) @(posedge pclk);
        lvl <= 9'h0;
        @(posedge pclk);
    endtask
endmodule

// ==== verif/peqm_tb.sv ====
`include "peqm_defines.svh"
module perf_event_qualifier_match_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er, count_active;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0][31:0] req;
    logic [8:0] lvl;
    int bad_count, n_compared;
    peqm_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hub_req_valid(req[0][31]), .hub_sched(req[0][24]),
        .hub_bank(req[0][23]), .hub_evict(req[0][22:21]), .hub_locked(req[0][20]),
        .hub_l2_state(req[0][19:18]), .hub_l1_state(req[0][17:16]), .hub_full_line(req[0][15]),
        .hub_cca(req[0][14:13]), .hub_cmd(req[0][12:8]), .hub_core_coherent(req[0][7]),
        .hub_l1_writeback(req[0][6]), .hub_reg_target(req[0][5]), .hub_thread(req[0][4]),
        .hub_port(req[0][3:0]), .io_req_valid(req[1][31]), .io_unit(req[1][30:28]),
        .io_tid(req[1][27:23]), .io_did(req[1][22:17]), .io_prefetch(req[1][16]),
        .io_misaligned(req[1][15]), .io_len(req[1][14:6]), .io_size_log2(req[1][5:3]),
        .io_dir(req[1][2:0]), .mem_req_valid(req[2][31]), .mem_gid(req[2][7:3]),
        .mem_prefetch(req[2][2]), .mem_code(req[2][1]), .mem_thread(req[2][0]),
        .io_axi_beat(lvl[7:0]), .trace_drop(req[3][31]), .trace_drop_resp(req[3][3]),
        .trace_drop_port(req[3][2:0]), .trace_ovf_busy(lvl[8]), .count_active(count_active));
    peqm_far i_far (.pclk(pclk), .req(req), .lvl(lvl));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task wrap_up;
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            bad_count++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task cnt_is(input logic [31:0] e);
        repeat (3) @(posedge pclk);
        apb(1'b0, `PEQM_OFF_COUNT, 32'h0);
        check(rd, e);
    endtask
    task arm(input logic [4:0] ev, input logic [63:0] q);
        apb(1'b1, `PEQM_OFF_EVSEL, {27'h0, ev});
        apb(1'b1, `PEQM_OFF_QUAL_LO, q[31:0]);
        apb(1'b1, `PEQM_OFF_QUAL_HI, q[63:32]);
        apb(1'b1, `PEQM_OFF_COUNT, 32'h0);
    endtask
    task t_regs;
        apb(1'b0, `PEQM_OFF_QUAL_HI, 32'h0);
        check(rd, 32'hffffffff);
        apb(1'b0, 12'h020, 32'h0);
        check({rd[30:0], er}, 32'h1);
        apb(1'b1, `PEQM_OFF_EVSEL, 32'h12);
        apb(1'b0, `PEQM_OFF_EVSEL, 32'h0);
        check(rd, 32'h12);
        apb(1'b1, `PEQM_OFF_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
        check({31'h0, count_active}, 32'h1);
    endtask
    task t_hub;
        int hb[12];
        hb = '{59, 57, 54, 52, 48, 45, 43, 40, 16, 14, 10, 0};
        for (int i = 0; i < 12; i++) begin
            arm(5'h01, ~(64'h1 << hb[i]));
            i_far.send(0, 31'h0);
            cnt_is(32'h0);
        end
        arm(5'h01, '1);
        i_far.send(0, 31'h0);
        i_far.send(0, 31'h32);
        cnt_is(32'h2);
        arm(5'h01, ~(64'h1 << 17));
        i_far.send(0, 31'h1c0);
        cnt_is(32'h1);
        arm(5'h01, ~(64'h1 << 24));
        i_far.send(0, 31'h1c0);
        cnt_is(32'h0);
    endtask
    task t_io;
        logic [30:0] f;
        f = {3'd3, 5'd5, 6'd9, 2'b00, 9'd5, 3'd2, 3'd1};
        arm(5'h02, {22'h0, 5'd5, 1'b0, 6'd9, 1'b0, 4'b0101, 9'h008, 8'h04, 5'b00010, 3'd3});
        i_far.send(1, f);
        i_far.send(1, {f[30:28], 5'd6, f[22:0]});
        i_far.send(1, {f[30:23], 6'd8, f[16:0]});
        i_far.send(1, {f[30:17], 1'b1, f[15:0]});
        i_far.send(1, {f[30:15], 9'd9, f[5:0]});
        i_far.send(1, {f[30:6], 3'd3, f[2:0]});
        i_far.send(1, {f[30:3], 3'd4});
        i_far.send(1, {3'd4, f[27:0]});
        cnt_is(32'h1);
        arm(5'h02, {22'h0, 5'd5, 1'b1, 6'd9, 1'b1, 4'b0101, 9'h008, 8'h04, 5'b00010, 3'd3});
        i_far.send(1, {f[30:28], 5'd6, 6'd8, 2'b00, 9'd8, f[5:0]});
        cnt_is(32'h1);
    endtask
    task t_misc;
        arm(5'h03, {18'h3ffff, 5'd7, 2'b00, 39'h7fffffffff});
        i_far.send(2, 31'h38);
        i_far.send(2, 31'h40);
        i_far.send(2, 31'h3c);
        cnt_is(32'h1);
        arm(5'h11, 64'h84);
        i_far.send(3, 31'ha);
        i_far.send(3, 31'h2);
        i_far.send(3, 31'hb);
        cnt_is(32'h1);
        arm(5'h12, 64'h0);
        i_far.hold(9'h100, 4, 1);
        cnt_is(32'h4);
        for (int c = 9; c <= 15; c++) begin
            arm(c[4:0], '1);
            i_far.hold({1'b0, 8'h1 << (c - 8)}, 3, 2);
            cnt_is(32'h3);
        end
    endtask
    // wrap flag, status word, and a frozen count while clk_en is low
    task t_wrap;
        arm(5'h12, 64'h0);
        apb(1'b1, `PEQM_OFF_COUNT, 32'hffffffff);
        i_far.hold(9'h100, 1, 1);
        cnt_is(32'h0);
        apb(1'b0, `PEQM_OFF_STATUS, 32'h0);
        check(rd, 32'h6);
        apb(1'b1, `PEQM_OFF_COUNT, 32'h0);
        clk_en <= 1'b0;
        i_far.hold(9'h100, 3, 1);
        clk_en <= 1'b1;
        cnt_is(32'h0);
        apb(1'b0, `PEQM_OFF_STATUS, 32'h0);
        check(rd, 32'h4);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        clk_en = 1'b1;
        presetn = 1'b0;
        bad_count = 0;
        n_compared = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_hub();
        t_io();
        t_misc();
        t_wrap();
        wrap_up();
    end
endmodule
